// ===== inc/legality_pkg.sv
// Purpose: constants shared by the opcode legality checker
// Assumes: 32-bit instruction words, primary opcode in bits 31:26
// Notes: opcode, function and format codes of the instruction set
package legality_pkg;
  localparam int unsigned OP_HI = 31;
  localparam int unsigned OP_LO = 26;
  localparam int unsigned RS_HI = 25;
  localparam int unsigned RS_LO = 21;
  localparam int unsigned RT_HI = 20;
  localparam int unsigned RT_LO = 16;
  localparam int unsigned RD_HI = 15;
  localparam int unsigned RD_LO = 11;
  localparam int unsigned FN_HI = 5;
  localparam int unsigned FN_LO = 0;
  localparam int unsigned BCLIKELY_BIT = 17;
  localparam int unsigned CP_REG_W = 5;
  localparam int unsigned CP_IF_COUNT = 12;

  // primary opcodes
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_REGIMM = 6'h01;
  localparam logic [5:0] OP_COP0 = 6'h10;
  localparam logic [5:0] OP_COP1 = 6'h11;
  localparam logic [5:0] OP_CP2 = 6'h12;
  localparam logic [5:0] OP_COP1X = 6'h13;
  localparam logic [5:0] OP_VFC = 6'h1c;
  localparam logic [5:0] OP_LWC2 = 6'h32;
  localparam logic [5:0] OP_LDC2 = 6'h36;
  localparam logic [5:0] OP_SWC2 = 6'h3a;
  localparam logic [5:0] OP_SDC2 = 6'h3e;

  // coprocessor rs codes
  localparam logic [4:0] RS_MF = 5'h00;
  localparam logic [4:0] RS_DMF = 5'h01;
  localparam logic [4:0] RS_CF = 5'h02;
  localparam logic [4:0] RS_MT = 5'h04;
  localparam logic [4:0] RS_DMT = 5'h05;
  localparam logic [4:0] RS_CT = 5'h06;
  localparam logic [4:0] RS_BC = 5'h08;
  localparam logic [4:0] RS_BC_ANY2 = 5'h09;
  localparam logic [4:0] RS_BC_ANY4 = 5'h0a;
  localparam logic [4:0] RS_FMT_S = 5'h10;
  localparam logic [4:0] RS_FMT_D = 5'h11;
  localparam logic [4:0] RS_FMT_W = 5'h14;
  localparam logic [4:0] RS_FMT_L = 5'h15;
  localparam logic [4:0] RS_FMT_PAIRED = 5'h16;

  // bit positions in the supported coprocessor interface set
  localparam int unsigned CI_BC = 0;
  localparam int unsigned CI_CF = 1;
  localparam int unsigned CI_OP = 2;
  localparam int unsigned CI_CT = 3;
  localparam int unsigned CI_DMF = 4;
  localparam int unsigned CI_DMT = 5;
  localparam int unsigned CI_LD = 6;
  localparam int unsigned CI_LW = 7;
  localparam int unsigned CI_MF = 8;
  localparam int unsigned CI_MT = 9;
  localparam int unsigned CI_SD = 10;
  localparam int unsigned CI_SW = 11;
  localparam logic [11:0] CI_ALL = 12'hfff;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h1,
    CAUSE_RESERVED = 3'h2,
    CAUSE_UNUSABLE = 3'h4
  } cause_e;
endpackage

// ===== hdl/opcode_legality_checker.sv
// Purpose: decide per instruction word: execute, reserved instruction, or
//   coprocessor unusable
// Assumes: inputs synchronous to clock; one word offered per valid cycle
// Notes: decision is combinational, registered once so outputs come from flops
// Overview of operation
// - coprocessor register specifier limited to 32
// - supported coprocessor interface subset is a parameter
// - omitted coprocessor interface op traps reserved
// - reserved codes trap reserved, unusable instead for a locked coprocessor; no other effect
// - field class opcodes decoded by further field
// - higher ISA level encodings trap reserved
// - 64-bit encodings run in kernel, debug, enabled; COP1X, paired single, long fixed need enabled
// - otherwise reserved, or unusable for disallowed coprocessor
// - unassigned partner codes: reserved only, never unusable
// - compat mode: paired single, long fixed illegal
// - long fixed format needs 64-bit enabled
`timescale 1ns/1ps
`default_nettype none
module opcode_legality_checker #(
  parameter logic [11:0] CP_IF_SUPPORTED = legality_pkg::CI_ALL,
  parameter bit CP_PRESENT = 1'b1,
  parameter logic [63:0] VFC_ASSIGNED = 64'h8000_0003_0000_0037
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic kernel_mode,
  input wire logic debug_mode,
  input wire logic ops64_enabled,
  input wire logic compat32_mode,
  input wire logic [3:0] cp_usable,
  output logic result_valid,
  output logic exec_ok,
  output logic reserved_exc,
  output logic unusable_exc,
  output logic [1:0] unusable_cp,
  output logic cp_if_issue,
  output logic [4:0] cp_reg_sel
);
  ////////////////////////////////////////////////////////////////////////
  logic [5:0] opc;
  logic [4:0] rs;
  logic [4:0] rt;
  logic [5:0] fn;
  logic [1:0] cpn;
  logic is_cop;
  logic cp_ok;
  logic rsv;
  logic need64;
  logic partner;
  logic ci_hit;
  int unsigned ci_idx;
  legality_pkg::cause_e cause;

  always_comb begin
    opc = instr_word[legality_pkg::OP_HI:legality_pkg::OP_LO];
    rs = instr_word[legality_pkg::RS_HI:legality_pkg::RS_LO];
    rt = instr_word[legality_pkg::RT_HI:legality_pkg::RT_LO];
    fn = instr_word[legality_pkg::FN_HI:legality_pkg::FN_LO];
    is_cop = 1'b0;
    cpn = 2'h0;
    rsv = 1'b0;
    need64 = 1'b0;
    partner = 1'b0;
    ci_hit = 1'b0;
    ci_idx = 0;
    // coprocessor number: COPz in bits 27:26, LWCz/SWCz/LDCz/SDCz likewise
    if (opc[5:2] == 4'h4 && opc != legality_pkg::OP_COP1X) begin
      is_cop = 1'b1;
      cpn = opc[1:0];
    end else if (opc == legality_pkg::OP_COP1X) begin
      is_cop = 1'b1;
      cpn = 2'h1;
    end else if (opc[5:4] == 2'h3 && opc[1:0] != 2'h0 && opc[1:0] != 2'h3) begin
      is_cop = 1'b1;
      cpn = opc[1:0];
    end
    unique case (opc)
      // field classes select the real operation by a second field
      legality_pkg::OP_SPECIAL: begin
        unique case (fn)
          6'h05, 6'h0e, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3d:
            rsv = 1'b1;
          6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2c, 6'h2d,
          6'h2e, 6'h2f, 6'h38, 6'h3a, 6'h3b, 6'h3c, 6'h3e, 6'h3f:
            need64 = 1'b1;
          default: ;
        endcase
      end
      legality_pkg::OP_REGIMM: begin
        if (rt[4:3] == 2'h3 || (rt[2] && !rt[3]) || rt == 5'h0d || rt == 5'h0f)
          rsv = 1'b1;
      end
      legality_pkg::OP_VFC: begin
        if (fn == 6'h24 || fn == 6'h25)
          need64 = 1'b1;
        else if (!VFC_ASSIGNED[fn])
          partner = 1'b1;
      end
      legality_pkg::OP_COP0, legality_pkg::OP_COP1, legality_pkg::OP_CP2: begin
        if (!rs[4]) begin
          unique case (rs)
            legality_pkg::RS_MF: ci_idx = legality_pkg::CI_MF;
            legality_pkg::RS_MT: ci_idx = legality_pkg::CI_MT;
            legality_pkg::RS_CF: ci_idx = legality_pkg::CI_CF;
            legality_pkg::RS_CT: ci_idx = legality_pkg::CI_CT;
            legality_pkg::RS_BC: ci_idx = legality_pkg::CI_BC;
            legality_pkg::RS_DMF: begin
              ci_idx = legality_pkg::CI_DMF;
              need64 = 1'b1;
            end
            legality_pkg::RS_DMT: begin
              ci_idx = legality_pkg::CI_DMT;
              need64 = 1'b1;
            end
            legality_pkg::RS_BC_ANY2, legality_pkg::RS_BC_ANY4: begin
              rsv = (opc != legality_pkg::OP_COP1);
              need64 = 1'b1;
            end
            default: rsv = 1'b1;
          endcase
          if (opc == legality_pkg::OP_COP0 &&
              (rs == legality_pkg::RS_CF || rs == legality_pkg::RS_CT ||
               rs == legality_pkg::RS_BC))
            rsv = 1'b1;
          // branch-likely forms (bit 17) stay decoded for old code
          if (rs == legality_pkg::RS_BC && rt[4:2] != 3'h0)
            rsv = 1'b1;
          ci_hit = (opc == legality_pkg::OP_CP2);
        end else if (opc == legality_pkg::OP_COP1) begin
          unique case (rs)
            legality_pkg::RS_FMT_S, legality_pkg::RS_FMT_D,
            legality_pkg::RS_FMT_W: ;
            legality_pkg::RS_FMT_L, legality_pkg::RS_FMT_PAIRED: begin
              need64 = 1'b1;
              if (compat32_mode || !ops64_enabled)
                rsv = 1'b1;
            end
            default: rsv = 1'b1;
          endcase
        end else if (opc == legality_pkg::OP_CP2) begin
          ci_hit = 1'b1;
          ci_idx = legality_pkg::CI_OP;
        end
      end
      legality_pkg::OP_COP1X: begin
        need64 = 1'b1;
        if (!ops64_enabled)
          rsv = 1'b1;
      end
      legality_pkg::OP_LWC2, legality_pkg::OP_SWC2, legality_pkg::OP_LDC2,
      legality_pkg::OP_SDC2: begin
        ci_hit = 1'b1;
        unique case (opc)
          legality_pkg::OP_LWC2: ci_idx = legality_pkg::CI_LW;
          legality_pkg::OP_SWC2: ci_idx = legality_pkg::CI_SW;
          legality_pkg::OP_LDC2: ci_idx = legality_pkg::CI_LD;
          default: ci_idx = legality_pkg::CI_SD;
        endcase
      end
      // higher-level and unused primary codes trap reserved; 64-bit primary codes need 64-bit access
      6'h1d, 6'h1e, 6'h1f, 6'h3b: rsv = 1'b1;
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d, 6'h34, 6'h37, 6'h3c,
      6'h3f: need64 = 1'b1;
      default: ;
    endcase
    cp_ok = !is_cop || cp_usable[cpn] || (cpn == 2'h0 && kernel_mode);
    // single cause, unusable wins over reserved for a locked coprocessor
    cause = legality_pkg::CAUSE_NONE;
    if (is_cop && !cp_ok && (rsv || partner || need64 || ci_hit))
      cause = legality_pkg::CAUSE_UNUSABLE;
    else if (rsv || partner)
      cause = legality_pkg::CAUSE_RESERVED;
    else if (need64 && !(kernel_mode || debug_mode || ops64_enabled))
      cause = legality_pkg::CAUSE_RESERVED;
    else if (ci_hit && CP_PRESENT && !CP_IF_SUPPORTED[ci_idx])
      cause = legality_pkg::CAUSE_RESERVED;
    else if (is_cop && !cp_ok)
      cause = legality_pkg::CAUSE_UNUSABLE;
  end

  ////////////////////////////////////////////////////////////////////////
  logic result_valid_d, exec_ok_d, reserved_d, unusable_d, issue_d;
  logic result_valid_q, exec_ok_q, reserved_q, unusable_q, issue_q;
  logic [1:0] ucp_d, ucp_q;
  logic [4:0] reg_d, reg_q;

  always_comb begin
    result_valid_d = instr_valid;
    exec_ok_d = instr_valid && cause == legality_pkg::CAUSE_NONE;
    reserved_d = instr_valid && cause == legality_pkg::CAUSE_RESERVED;
    unusable_d = instr_valid && cause == legality_pkg::CAUSE_UNUSABLE;
    ucp_d = unusable_d ? cpn : 2'h0;
    // trapped words produce no coprocessor traffic
    issue_d = exec_ok_d && ci_hit;
    // load/store rt names one of 32 registers; the field width caps it
    reg_d = issue_d ? rt[legality_pkg::CP_REG_W-1:0] : 5'h00;
    if (srst) begin
      result_valid_d = 1'b0;
      exec_ok_d = 1'b0;
      reserved_d = 1'b0;
      unusable_d = 1'b0;
      ucp_d = 2'h0;
      issue_d = 1'b0;
      reg_d = 5'h00;
    end
  end

  always_ff @(posedge clock) begin
    result_valid_q <= result_valid_d;
    exec_ok_q <= exec_ok_d;
    reserved_q <= reserved_d;
    unusable_q <= unusable_d;
    ucp_q <= ucp_d;
    issue_q <= issue_d;
    reg_q <= reg_d;
  end

  assign result_valid = result_valid_q;
  assign exec_ok = exec_ok_q;
  assign reserved_exc = reserved_q;
  assign unusable_exc = unusable_q;
  assign unusable_cp = ucp_q;
  assign cp_if_issue = issue_q;
  assign cp_reg_sel = reg_q;
endmodule
`default_nettype wire

// ===== verification/legality_properties.sv
// Purpose: port assertions for the opcode legality checker
// Assumes: one clock domain, srst synchronous active high
// Notes: bound to the design by the bind after the module
`timescale 1ns/1ps
`default_nettype none
module legality_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic kernel_mode,
  input wire logic debug_mode,
  input wire logic ops64_enabled,
  input wire logic compat32_mode,
  input wire logic [3:0] cp_usable,
  input wire logic result_valid,
  input wire logic exec_ok,
  input wire logic reserved_exc,
  input wire logic unusable_exc,
  input wire logic [1:0] unusable_cp,
  input wire logic cp_if_issue,
  input wire logic [4:0] cp_reg_sel
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);
  one_cause_a: assert property (result_valid |-> $onehot({exec_ok, reserved_exc, unusable_exc}))
    else $error("cause count wrong");
  answer_lat_a: assert property (instr_valid |=> result_valid)
    else $error("answer missing");
  idle_quiet_a: assert property (!instr_valid |=> !result_valid && !exec_ok && !reserved_exc)
    else $error("output without word");
  reg_sel_a: assert property (cp_if_issue |-> cp_reg_sel == $past(instr_word[20:16]))
    else $error("register select wrong");
  sel_idle_a: assert property (!cp_if_issue |-> cp_reg_sel == 5'h00)
    else $error("register select not clear");
  unusable_num_a: assert property (unusable_exc && $past(instr_word[31:26]) != 6'h13
    |-> unusable_cp == $past(instr_word[27:26])) else $error("unusable number wrong");
  reserved_op_a: assert property (instr_valid && instr_word[31:26] == 6'h1f |=> reserved_exc)
    else $error("reserved opcode ran");
  wide_run_a: assert property (instr_valid && instr_word[31:26] == 6'h37 &&
    (kernel_mode || debug_mode || ops64_enabled) |=> exec_ok) else $error("wide op trapped");
  wide_trap_a: assert property (instr_valid && instr_word[31:26] == 6'h37 && !kernel_mode &&
    !debug_mode && !ops64_enabled |=> reserved_exc) else $error("wide op ran");
  cover property (exec_ok);
  cover property (reserved_exc);
  cover property (unusable_exc);
  cover property (cp_if_issue);
endmodule
bind opcode_legality_checker legality_properties chk (.clock(clock), .srst(srst),
  .instr_valid(instr_valid), .instr_word(instr_word), .kernel_mode(kernel_mode),
  .debug_mode(debug_mode), .ops64_enabled(ops64_enabled), .compat32_mode(compat32_mode),
  .cp_usable(cp_usable), .result_valid(result_valid), .exec_ok(exec_ok),
  .reserved_exc(reserved_exc), .unusable_exc(unusable_exc), .unusable_cp(unusable_cp),
  .cp_if_issue(cp_if_issue), .cp_reg_sel(cp_reg_sel));
`default_nettype wire

// ===== verification/coproc_model.sv
// Purpose: attached coprocessor, records issued interface words
// Assumes: issue is a one-cycle pulse
// Notes: drives nothing back, so no stale-value hazard on shared lines
`timescale 1ns/1ps
`default_nettype none
module coproc_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic cp_if_issue,
  input wire logic [4:0] cp_reg_sel,
  output logic [7:0] issue_count,
  output logic [4:0] last_reg
);
  always_ff @(posedge clock) begin
    if (srst) begin
      issue_count <= 8'h00;
      last_reg <= 5'h00;
    end else if (cp_if_issue) begin
      issue_count <= issue_count + 8'h01;
      last_reg <= cp_reg_sel;
    end
  end
endmodule
`default_nettype wire

// ===== verification/opcode_legality_checker_tb.sv
// Purpose: directed bench for the opcode legality checker
// Assumes: store-word interface op left out of the supported set
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module opcode_legality_checker_tb;
  logic clock = 1'b0, srst = 1'b1, instr_valid = 1'b0, kernel_mode = 1'b0, debug_mode = 1'b0;
  logic ops64_enabled = 1'b0, compat32_mode = 1'b0, result_valid, exec_ok, reserved_exc;
  logic unusable_exc, cp_if_issue;
  logic [31:0] instr_word = 32'h0000_0000;
  logic [3:0] cp_usable = 4'h0;
  logic [1:0] unusable_cp;
  logic [4:0] cp_reg_sel, last_reg;
  logic [7:0] issue_count;
  int mismatches = 0, samples_checked = 0;
  always #5 clock = ~clock;
  opcode_legality_checker #(.CP_IF_SUPPORTED(12'h7ff)) DUT (.clock(clock), .srst(srst),
    .instr_valid(instr_valid), .instr_word(instr_word), .kernel_mode(kernel_mode),
    .debug_mode(debug_mode), .ops64_enabled(ops64_enabled), .compat32_mode(compat32_mode),
    .cp_usable(cp_usable), .result_valid(result_valid), .exec_ok(exec_ok),
    .reserved_exc(reserved_exc), .unusable_exc(unusable_exc), .unusable_cp(unusable_cp),
    .cp_if_issue(cp_if_issue), .cp_reg_sel(cp_reg_sel));
  coproc_model partner (.clock(clock), .srst(srst), .cp_if_issue(cp_if_issue),
    .cp_reg_sel(cp_reg_sel), .issue_count(issue_count), .last_reg(last_reg));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected code: {unusable_cp, unusable_exc, reserved_exc, exec_ok}
  task automatic run(input logic [31:0] w, input logic [4:0] exp);
    @(negedge clock);
    instr_word = w;
    instr_valid = 1'b1;
    @(negedge clock);
    instr_valid = 1'b0;
    chk({3'h0, unusable_cp, unusable_exc, reserved_exc, exec_ok}, {3'h0, exp});
    chk({7'h00, result_valid}, 8'h01);
  endtask
  task automatic sm(input logic [3:0] m);
    {kernel_mode, debug_mode, ops64_enabled, compat32_mode} = m;
  endtask
  task automatic t_codes;
    run(32'h7c00_0000, 5'h02);
    run(32'hec00_0000, 5'h02);
    run(32'h0000_0005, 5'h02);
    run(32'h0000_0020, 5'h01);
    run(32'h0404_0000, 5'h02);
  endtask
  task automatic t_wide;
    sm(4'h1);
    run(32'hdc00_0000, 5'h02);
    sm(4'h9);
    run(32'hdc00_0000, 5'h01);
    sm(4'h5);
    run(32'hdc00_0000, 5'h01);
    sm(4'h3);
    run(32'hdc00_0000, 5'h01);
    sm(4'h0);
    run(32'h4420_0000, 5'h0c);
    cp_usable = 4'h2;
    run(32'h4420_0000, 5'h02);
  endtask
  task automatic t_partner;
    run(32'h7000_0003, 5'h02);
    run(32'h7000_0002, 5'h01);
    run(32'h7000_0020, 5'h01);
    run(32'h7000_0010, 5'h02);
    run(32'h4a00_0000, 5'h14);
  endtask
  task automatic t_coprocessor_two_operation;
    cp_usable = 4'h4;
    run(32'hc81f_0000, 5'h01);
    @(negedge clock);
    chk({3'h0, last_reg}, 8'h1f);
    run(32'he800_0000, 5'h02);
    chk(issue_count, 8'h01);
    cp_usable = 4'h0;
    run(32'hc800_0000, 5'h14);
  endtask
  task automatic t_fp;
    cp_usable = 4'h2;
    sm(4'hb);
    run(32'h46c0_0000, 5'h02);
    sm(4'h8);
    run(32'h46a0_0020, 5'h02);
    sm(4'h2);
    run(32'h46a0_0020, 5'h01);
    run(32'h4502_0000, 5'h01);
  endtask
  // a word offered during a mid-run reset must leave no answer behind
  task automatic t_reset;
    @(negedge clock);
    instr_word = 32'h0000_0020;
    instr_valid = 1'b1;
    srst = 1'b1;
    @(negedge clock);
    instr_valid = 1'b0;
    srst = 1'b0;
    chk({result_valid, exec_ok, reserved_exc, unusable_exc, cp_if_issue, unusable_cp, 1'b0},
      8'h00);
    chk({3'h0, cp_reg_sel}, 8'h00);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    t_codes();
    t_wide();
    t_partner();
    t_coprocessor_two_operation();
    t_fp();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
